// File: design/otg_interrupt_event_logic.sv
// OTG interrupt source edge detection, enable registers and sticky latch
`timescale 1ns/1ps
module otg_interrupt_event_logic
    import otg_event_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // Source levels from detectors and comparators
    input wire sources_s sources,
    // Power state: high while low-power mode is requested
    input wire logic low_power,
    // Register access
    input wire reg_req_s req,
    output logic [7:0] rdata,
    output logic rdata_valid,
    // Event toward the RXCMD sender
    output logic rxcmd_req,
    output sources_s rxcmd_sources,
    // Register views
    output logic [4:0] rise_event_enable,
    output logic [4:0] fall_event_enable,
    output logic [4:0] sticky_event_latch
);
    logic [4:0] prev_src;
    logic prev_low_power;
    logic [4:0] rise_hit;
    logic [4:0] fall_hit;
    logic [4:0] edge_hit;
    logic latch_read;
    logic lp_entry;

    // Registers on write/set/clear sub-addresses
    function automatic logic [4:0] upd(input logic [4:0] cur, input logic [1:0] op, input logic [4:0] d);
        logic [4:0] r;
        r = cur;
        unique case (op)
            2'h1: r = d;
            2'h2: r = cur | d;
            2'h3: r = cur & ~d;
            default: r = cur;
        endcase
        return r;
    endfunction

    // Picks the write operation for a three-address register block
    function automatic logic [1:0] op_of(input logic [5:0] a, input logic [5:0] base);
        logic [1:0] r;
        r = 2'h0;
        if (a == base)
            r = 2'h1;
        else if (a == base + 6'h01)
            r = 2'h2;
        else if (a == base + 6'h02)
            r = 2'h3;
        return r;
    endfunction

    assign rise_hit = ~prev_src & sources & rise_event_enable;
    assign fall_hit = prev_src & ~sources & fall_event_enable;
    assign edge_hit = rise_hit | fall_hit;
    assign latch_read = req.rd && req.addr == LATCH_ADDR;
    assign lp_entry = low_power && !prev_low_power;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            prev_src <= sources_s'(5'h00);
            prev_low_power <= 1'b0;
        end
        else if (clk_en)
        begin
            prev_src <= sources;
            prev_low_power <= low_power;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rise_event_enable <= ENABLE_RESET;
            fall_event_enable <= ENABLE_RESET;
        end
        else if (clk_en && req.wr)
        begin
            rise_event_enable <= upd(rise_event_enable, op_of(req.addr, RISE_WR_ADDR), req.wdata[4:0]);
            fall_event_enable <= upd(fall_event_enable, op_of(req.addr, FALL_WR_ADDR), req.wdata[4:0]);
        end
    end

    // Low-power entry and a latch read both clear; a new edge in that cycle still sets
    always_ff @(posedge clock)
    begin
        if (rst)
            sticky_event_latch <= LATCH_RESET;
        else if (clk_en)
        begin
            if (latch_read || lp_entry)
                sticky_event_latch <= edge_hit;
            else
                sticky_event_latch <= sticky_event_latch | edge_hit;
        end
    end

    // RXCMD carries live levels, so link need not poll the latch
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rxcmd_req <= 1'b0;
            rxcmd_sources <= sources_s'(5'h00);
        end
        else if (clk_en)
        begin
            rxcmd_req <= |edge_hit;
            rxcmd_sources <= sources;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            rdata_valid <= req.rd;
            rdata <= 8'h00;
            if (req.rd)
            begin
                if (req.addr >= RISE_WR_ADDR && req.addr <= RISE_CLR_ADDR)
                    rdata <= {RESERVED_READ, rise_event_enable};
                else if (req.addr >= FALL_WR_ADDR && req.addr <= FALL_CLR_ADDR)
                    rdata <= {RESERVED_READ, fall_event_enable};
                else if (req.addr == STATUS_ADDR)
                    rdata <= {RESERVED_READ, sources};
                else if (req.addr == LATCH_ADDR)
                    rdata <= {RESERVED_READ, sticky_event_latch};
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    rise_latch_a: assert property (clk_en && rise_hit[ID_BIT] |=> sticky_event_latch[ID_BIT])
        else $error("rising edge did not latch");
    fall_rxcmd_a: assert property (clk_en && |fall_hit |=> rxcmd_req)
        else $error("falling edge gave no rxcmd");
    rise_rxcmd_a: assert property (clk_en && |rise_hit |=> rxcmd_req)
        else $error("rising edge gave no rxcmd");
    no_edge_quiet_a: assert property (clk_en && edge_hit == 5'h00 |=> !rxcmd_req)
        else $error("rxcmd without edge");
    read_clear_a: assert property (clk_en && latch_read && edge_hit == 5'h00 |=> sticky_event_latch == 5'h00)
        else $error("latch read did not clear");
    lp_clear_a: assert property (clk_en && lp_entry && edge_hit == 5'h00 |=> sticky_event_latch == 5'h00)
        else $error("low power did not clear latch");
    status_read_a: assert property (clk_en && req.rd && req.addr == STATUS_ADDR |=> rdata == {3'h0, $past(sources)})
        else $error("status read wrong");
    set_bits_a: assert property (clk_en && req.wr && req.addr == RISE_SET_ADDR
        |=> rise_event_enable == ($past(rise_event_enable) | $past(req.wdata[4:0])))
        else $error("bit set wrong");
    clr_bits_a: assert property (clk_en && req.wr && req.addr == FALL_CLR_ADDR
        |=> fall_event_enable == ($past(fall_event_enable) & ~$past(req.wdata[4:0])))
        else $error("bit clear wrong");
    masked_edge_a: assert property (clk_en && !rise_event_enable[UNPLUG_BIT] && !fall_event_enable[UNPLUG_BIT]
        && !latch_read && !lp_entry |=> $stable(sticky_event_latch[UNPLUG_BIT]))
        else $error("masked source latched");

    sessover_rise_a: assert property (clk_en && rise_hit[SESSOVER_BIT]
        |=> sticky_event_latch[SESSOVER_BIT])
        else $error("session end rise did not latch");

    sessok_rise_a: assert property (clk_en && rise_hit[SESSOK_BIT]
        |=> sticky_event_latch[SESSOK_BIT])
        else $error("session valid rise did not latch");

    buspower_rise_a: assert property (clk_en && rise_hit[BUSPOWER_BIT]
        |=> sticky_event_latch[BUSPOWER_BIT])
        else $error("bus power rise did not latch");

    unplug_rise_a: assert property (clk_en && rise_hit[UNPLUG_BIT]
        |=> sticky_event_latch[UNPLUG_BIT])
        else $error("disconnect rise did not latch");

    id_fall_a: assert property (clk_en && fall_hit[ID_BIT]
        |=> sticky_event_latch[ID_BIT])
        else $error("id fall did not latch");

    sessover_fall_a: assert property (clk_en && fall_hit[SESSOVER_BIT]
        |=> sticky_event_latch[SESSOVER_BIT])
        else $error("session end fall did not latch");

    sessok_fall_a: assert property (clk_en && fall_hit[SESSOK_BIT]
        |=> sticky_event_latch[SESSOK_BIT])
        else $error("session valid fall did not latch");

    buspower_fall_a: assert property (clk_en && fall_hit[BUSPOWER_BIT]
        |=> sticky_event_latch[BUSPOWER_BIT])
        else $error("bus power fall did not latch");

    unplug_fall_a: assert property (clk_en && fall_hit[UNPLUG_BIT]
        |=> sticky_event_latch[UNPLUG_BIT])
        else $error("disconnect fall did not latch");

    snap_track_a: assert property (clk_en
        |=> rxcmd_sources == $past(sources))
        else $error("rxcmd snapshot stale");

    rise_reset_a: assert property ($fell(rst)
        |-> rise_event_enable == ENABLE_RESET)
        else $error("rising enable reset value wrong");

    fall_reset_a: assert property ($fell(rst)
        |-> fall_event_enable == ENABLE_RESET)
        else $error("falling enable reset value wrong");

    latch_reset_a: assert property ($fell(rst)
        |-> sticky_event_latch == LATCH_RESET)
        else $error("latch reset value wrong");

    rxcmd_reset_a: assert property ($fell(rst)
        |-> !rxcmd_req && rxcmd_sources == 5'h00)
        else $error("rxcmd not idle after reset");

    rise_write_a: assert property (clk_en && req.wr && req.addr == RISE_WR_ADDR
        |=> rise_event_enable == $past(req.wdata[4:0]))
        else $error("rising enable write wrong");

    fall_write_a: assert property (clk_en && req.wr && req.addr == FALL_WR_ADDR
        |=> fall_event_enable == $past(req.wdata[4:0]))
        else $error("falling enable write wrong");

    rise_clr_a: assert property (clk_en && req.wr && req.addr == RISE_CLR_ADDR
        |=> rise_event_enable == ($past(rise_event_enable) & ~$past(req.wdata[4:0])))
        else $error("rising bit clear wrong");

    fall_set_a: assert property (clk_en && req.wr && req.addr == FALL_SET_ADDR
        |=> fall_event_enable == ($past(fall_event_enable) | $past(req.wdata[4:0])))
        else $error("falling bit set wrong");

    enable_hold_a: assert property (clk_en && !req.wr
        |=> $stable(rise_event_enable) && $stable(fall_event_enable))
        else $error("enable changed without write");

    freeze_hold_a: assert property (!clk_en
        |=> $stable(sticky_event_latch) && $stable(rxcmd_req) && $stable(rise_event_enable))
        else $error("state moved while frozen");

    read_valid_a: assert property (clk_en && req.rd
        |=> rdata_valid)
        else $error("read gave no valid");

    read_quiet_a: assert property (clk_en && !req.rd
        |=> !rdata_valid && rdata == 8'h00)
        else $error("read data without read");

    rise_read_a: assert property (clk_en && req.rd && req.addr >= RISE_WR_ADDR && req.addr <= RISE_CLR_ADDR
        |=> rdata == {3'h0, $past(rise_event_enable)})
        else $error("rising enable read wrong");

    fall_read_a: assert property (clk_en && req.rd && req.addr >= FALL_WR_ADDR && req.addr <= FALL_CLR_ADDR
        |=> rdata == {3'h0, $past(fall_event_enable)})
        else $error("falling enable read wrong");

    latch_read_a: assert property (clk_en && latch_read
        |=> rdata == {3'h0, $past(sticky_event_latch)})
        else $error("latch read wrong");

    unmapped_read_a: assert property (clk_en && req.rd && req.addr > LATCH_ADDR
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    reserved_zero_a: assert property (rdata_valid
        |-> rdata[7:5] == 3'h0)
        else $error("reserved bits not zero");

    id_status_a: assert property (clk_en && req.rd && req.addr == STATUS_ADDR
        |=> rdata[ID_BIT] == $past(sources.id_grounded))
        else $error("id status bit wrong");

    sessover_status_a: assert property (clk_en && req.rd && req.addr == STATUS_ADDR
        |=> rdata[SESSOVER_BIT] == $past(sources.session_over))
        else $error("session end status bit wrong");

    sessok_status_a: assert property (clk_en && req.rd && req.addr == STATUS_ADDR
        |=> rdata[SESSOK_BIT] == $past(sources.session_ok))
        else $error("session valid status bit wrong");

    buspower_status_a: assert property (clk_en && req.rd && req.addr == STATUS_ADDR
        |=> rdata[BUSPOWER_BIT] == $past(sources.bus_power_ok))
        else $error("bus power status bit wrong");

    unplug_status_a: assert property (clk_en && req.rd && req.addr == STATUS_ADDR
        |=> rdata[UNPLUG_BIT] == $past(sources.host_unplugged))
        else $error("disconnect status bit wrong");

    latch_keep_a: assert property (clk_en && !latch_read && !lp_entry
        |=> (sticky_event_latch & $past(sticky_event_latch)) == $past(sticky_event_latch))
        else $error("latch lost a bit");

    latch_cause_a: assert property (clk_en
        |=> (sticky_event_latch & ~$past(sticky_event_latch) & ~$past(edge_hit)) == 5'h00)
        else $error("latch set without edge");

    set_wins_a: assert property (clk_en && latch_read && edge_hit != 5'h00
        |=> sticky_event_latch == $past(edge_hit))
        else $error("edge lost in clear cycle");

    rise_seen_c: cover property (|rise_hit);
    fall_seen_c: cover property (|fall_hit);
    read_clear_c: cover property (latch_read && sticky_event_latch != 5'h00);
    lp_clear_c: cover property (lp_entry && sticky_event_latch != 5'h00);
endmodule // otg_interrupt_event_logic

// File: design/otg_event_pkg.sv
// Package: register map, field layout and carriers for the OTG event logic
package otg_event_pkg;
    localparam int SRC_W = 5;
    localparam int REG_W = 8;
    localparam int ADDR_W = 6;
    localparam logic [5:0] RISE_WR_ADDR = 6'h0D;
    localparam logic [5:0] RISE_SET_ADDR = 6'h0E;
    localparam logic [5:0] RISE_CLR_ADDR = 6'h0F;
    localparam logic [5:0] FALL_WR_ADDR = 6'h10;
    localparam logic [5:0] FALL_SET_ADDR = 6'h11;
    localparam logic [5:0] FALL_CLR_ADDR = 6'h12;
    localparam logic [5:0] STATUS_ADDR = 6'h13;
    localparam logic [5:0] LATCH_ADDR = 6'h14;
    localparam int ID_BIT = 4;
    localparam int SESSOVER_BIT = 3;
    localparam int SESSOK_BIT = 2;
    localparam int BUSPOWER_BIT = 1;
    localparam int UNPLUG_BIT = 0;
    localparam logic [4:0] ENABLE_RESET = 5'h1F;
    localparam logic [4:0] LATCH_RESET = 5'h00;
    localparam logic [2:0] RESERVED_READ = 3'h0;

    // Five sources in bit order 4..0
    typedef struct packed {
        logic id_grounded;
        logic session_over;
        logic session_ok;
        logic bus_power_ok;
        logic host_unplugged;
    } sources_s;

    // Register access request from the interface framing
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage

// File: sim/link_model.sv
// Link controller model issuing register requests on the event logic
`timescale 1ns/1ps
module link_model
    import otg_event_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register access
    output reg_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid
);
    initial req = '0;

    // Reads only on demand: latch polling is optional while clocked
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clock);
        req = '{wr, ~wr, a, d};
        @(negedge clock);
        req = '0;
        q = rdata_valid ? rdata : 8'hXX;
    endtask
endmodule // link_model

// File: sim/testbench.sv
// Self-checking bench for the OTG event logic
`timescale 1ns/1ps
module testbench
    import otg_event_pkg::*;
;
    logic clock;
    logic rst;
    logic clk_en;
    logic low_power;
    sources_s sources;
    reg_req_s req;
    logic [7:0] rdata;
    logic rdata_valid;
    logic rxcmd_req;
    sources_s rxcmd_sources;
    logic [4:0] rise_event_enable;
    logic [4:0] fall_event_enable;
    logic [4:0] sticky_event_latch;
    int err_count;
    int checked;

    otg_interrupt_event_logic dut_u (.clock(clock), .rst(rst), .clk_en(clk_en), .sources(sources),
        .low_power(low_power), .req(req), .rdata(rdata), .rdata_valid(rdata_valid), .rxcmd_req(rxcmd_req),
        .rxcmd_sources(rxcmd_sources), .rise_event_enable(rise_event_enable),
        .fall_event_enable(fall_event_enable), .sticky_event_latch(sticky_event_latch));
    link_model link_u (.clock(clock), .req(req), .rdata(rdata), .rdata_valid(rdata_valid));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] q;
        link_u.access(1'b0, a, 8'h00, q);
        chk("read data", exp, q);
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        link_u.access(1'b1, a, d, q);
    endtask

    // New source levels, then look one cycle later when the event pulse stands
    task automatic drive(input logic [4:0] s);
        @(negedge clock);
        sources = s;
        @(negedge clock);
    endtask

    task automatic reset_values();
        for (int a = 'h0D; a <= 'h12; a++)
            reg_rd(6'(a), 8'h1F);
        reg_rd(LATCH_ADDR, 8'h00);
        reg_rd(6'h3F, 8'h00);
    endtask

    task automatic enable_ops();
        for (int b = 'h0D; b <= 'h10; b += 3)
        begin
            reg_wr(6'(b), 8'hFF);
            reg_rd(6'(b + 2), 8'h1F);
            reg_wr(6'(b + 2), 8'h13);
            reg_rd(6'(b), 8'h0C);
            reg_wr(6'(b + 1), 8'h05);
            reg_rd(6'(b + 1), 8'h0D);
        end
    endtask

    // Both enables now 0Dh: id and bus power edges are masked
    task automatic edge_events();
        drive(5'h12);
        chk("masked pulse", 8'h00, {7'h0, rxcmd_req});
        drive(5'h1F);
        chk("rise pulse", 8'h01, {7'h0, rxcmd_req});
        chk("snapshot", 8'h1F, {3'h0, rxcmd_sources});
        reg_wr(STATUS_ADDR, 8'hFF);
        reg_rd(STATUS_ADDR, 8'h1F);
        reg_rd(LATCH_ADDR, 8'h0D);
        reg_rd(LATCH_ADDR, 8'h00);
        drive(5'h0A);
        chk("fall latch", 8'h05, {3'h0, sticky_event_latch});
        reg_rd(STATUS_ADDR, 8'h0A);
        low_power = 1'b1;
        drive(5'h0A);
        chk("sleep latch", 8'h00, {3'h0, sticky_event_latch});
        low_power = 1'b0;
    endtask

    // Edges arriving while frozen must be seen once the clock enable returns
    task automatic freeze_hold();
        clk_en = 1'b0;
        sources = 5'h15;
        repeat (2) @(negedge clock);
        chk("frozen pulse", 8'h00, {7'h0, rxcmd_req});
        chk("frozen latch", 8'h00, {3'h0, sticky_event_latch});
        chk("frozen snapshot", 8'h0A, {3'h0, rxcmd_sources});
        clk_en = 1'b1;
        @(negedge clock);
        chk("thaw latch", 8'h0D, {3'h0, sticky_event_latch});
        chk("thaw pulse", 8'h01, {7'h0, rxcmd_req});
        @(negedge clock);
        chk("pulse end", 8'h00, {7'h0, rxcmd_req});
        reg_rd(LATCH_ADDR, 8'h0D);
        reg_rd(LATCH_ADDR, 8'h00);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        err_count = 0;
        checked = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        low_power = 1'b0;
        sources = '0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        reset_values();
        enable_ops();
        edge_events();
        freeze_hold();
        wrap_up();
    end
endmodule // testbench
